// ### hw/pio_top.sv
// Purpose: Device control interface on a parallel I/O bus, APB set-up
// Assumes: Bus pulses are active high here and asynchronous to pclk
// Notes:   Command and strobe updates happen on synchronised trailing edges; normalize and skip test act on level
// Function
// - Skip test selects ready, busy or interrupt
// - Input ready stays clear until data arrives
// - Drive input bus only while addressed
// - Ready reset in input clears buffer, ready
// - Output strobe loads buffer; reset keeps it
// - Output: reset clears ready, take sets
// - Mask set samples own output bit
// - Interrupt request is ready and mask
// - Interrupt skip needs address, mask, ready
// - Pending input word held until taken
// - Output enable command also sets ready
// - Clear or power-on resets busy, ready, mask
// - Channel requests only while channel enabled
// - Channel mode uses channel address line
// - End of range stops channel requests
// - Block stop when data runs out
// - Parity error line to host
// - Write sets busy, ready; read busy only
// - Command records transfer direction
`timescale 1ns/10ps
`include "pio_regs.svh"
module pio_top (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [`PIO_ADDR_W-1:0] address_bus,
	input  wire logic [`PIO_FUNC_W-1:0] function_bus,
	input  wire logic [`PIO_DATA_W-1:0] output_bus,
	input  wire logic                   control_command,
	input  wire logic                   skip_test_cycle,
	input  wire logic                   output_strobe,
	input  wire logic                   ready_reset_pulse,
	input  wire logic                   mask_set_pulse,
	input  wire logic                   channel_address_line,
	input  wire logic                   end_of_range_pulse,
	input  wire logic                   master_clear_level,
	input  wire logic                   power_on_normalize_pulse,
	input  wire logic                   data_arrival_pulse,
	input  wire logic                   take_data_pulse,
	input  wire logic [`PIO_DATA_W-1:0] periph_data,
	input  wire logic                   periph_parity,
	input  wire logic                   periph_out_of_data,
	output logic      [`PIO_DATA_W-1:0] input_bus,
	output logic                        input_bus_oe,
	output logic      [`PIO_DATA_W-1:0] periph_word,
	output logic                        skip_response_line,
	output logic                        interrupt_request_line,
	output logic                        channel_service_request,
	output logic                        block_stop_line,
	output logic                        parity_error_input
);
	localparam int AW = `PIO_ADDR_W;
	localparam int FW = `PIO_FUNC_W;
	localparam int DW = `PIO_DATA_W;
	localparam int NP = `PIO_NPULSE;
	localparam int NL = `PIO_NLEVEL;

	pio_pkg::pio_state_type st_reg;
	pio_pkg::pio_state_type st_next;

	logic [NP-1:0] pulse_raw;
	logic [NL-1:0] level_raw;
	logic          normalize_level;

	pio_sync_if #(.W(NP)) pulse_if ();
	pio_sync_if #(.W(NL)) level_if ();

	// Clear and power-on merged before synchronising
	assign normalize_level = master_clear_level | power_on_normalize_pulse;

	// Pulse vector in index order
	always_comb begin
		pulse_raw                  = '0;
		pulse_raw[pio_pkg::PIO_P_CMD] = control_command;
		pulse_raw[pio_pkg::PIO_P_TEST] = skip_test_cycle;
		pulse_raw[pio_pkg::PIO_P_OTP] = output_strobe;
		pulse_raw[pio_pkg::PIO_P_RRL] = ready_reset_pulse;
		pulse_raw[pio_pkg::PIO_P_SMK] = mask_set_pulse;
		pulse_raw[pio_pkg::PIO_P_ARRIVE] = data_arrival_pulse;
		pulse_raw[pio_pkg::PIO_P_TAKE] = take_data_pulse;
		pulse_raw[pio_pkg::PIO_P_ERL] = end_of_range_pulse;
		pulse_raw[pio_pkg::PIO_P_NORM] = normalize_level;
	end

	// Bus levels sampled alongside the pulses
	assign level_raw = {periph_out_of_data, periph_parity, periph_data,
		output_bus, channel_address_line, function_bus, address_bus};

	// Every parallel-bus and peripheral pin passes the three-stage filter; APB pins do not
	pio_sync #(.W(NP)) u_pulse_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (pulse_raw),
		.sync    (pulse_if.src)
	);

	pio_sync #(.W(NL)) u_level_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (level_raw),
		.sync    (level_if.src)
	);

	// Synchronised bus fields
	logic [AW-1:0] s_addr;
	logic [FW-1:0] s_func;
	logic          s_chan;
	logic [DW-1:0] s_obus;
	logic [DW-1:0] s_pdata;
	logic          s_ppar;
	logic          s_oodata;
	logic [NP-1:0] p_fall;
	logic [NP-1:0] p_lvl;

	assign s_addr   = level_if.level[AW-1:0];
	assign s_func   = level_if.level[AW+FW-1:AW];
	assign s_chan   = level_if.level[AW+FW];
	assign s_obus   = level_if.level[AW+FW+DW:AW+FW+1];
	assign s_pdata  = level_if.level[AW+FW+2*DW:AW+FW+DW+1];
	assign s_ppar   = level_if.level[AW+FW+2*DW+1];
	assign s_oodata = level_if.level[AW+FW+2*DW+2];
	assign p_fall   = pulse_if.fall;
	assign p_lvl    = pulse_if.level;

	// Transfer select: channel line in channel mode, else address match
	function automatic logic xfer_sel(input logic [AW-1:0] a,
		input logic [AW-1:0] dev, input logic ch_en, input logic ch_ln);
		xfer_sel = ch_en ? ch_ln : (a == dev);
	endfunction : xfer_sel

	// APB register decode
	function automatic logic [1:0] reg_index(input logic [11:0] a,
		output logic hit);
		hit = 1'b1;
		case (a)
			`PIO_OFF_CTRL:   reg_index = 2'h0;
			`PIO_OFF_STATUS: reg_index = 2'h1;
			`PIO_OFF_BUFFER: reg_index = 2'h2;
			`PIO_OFF_FLAGS:  reg_index = 2'h3;
			default: begin
				reg_index = 2'h0;
				hit       = 1'b0;
			end
		endcase
	endfunction : reg_index

	logic       sel;
	logic       std_sel;
	logic       hit;
	logic [1:0] ridx;
	logic       apb_do;

	assign std_sel = (s_addr == st_reg.dev_addr);
	assign sel     = xfer_sel(s_addr, st_reg.dev_addr, st_reg.chan_en,
		s_chan);
	assign apb_do  = psel & penable & st_reg.pready;

	// Next-state logic of the whole interface
	always_comb begin
		logic test_hit;
		test_hit = 1'b0;
		ridx    = reg_index(paddr, hit);
		st_next = st_reg;

		// APB: one wait cycle, answer registered
		st_next.pready  = psel & penable & ~st_reg.pready;
		st_next.pslverr = 1'b0;
		st_next.prdata  = `PIO_RST_DATA;
		if (psel & penable & ~st_reg.pready) begin
			st_next.pslverr = ~hit;
			if (hit && !pwrite) begin
				case (ridx)
					2'h0: st_next.prdata = {20'h0_0000,
						st_reg.mask_bit, 2'h0, st_reg.dev_addr};
					2'h1: st_next.prdata = {24'h00_0000,
						st_reg.par_err, st_reg.overrun,
						st_reg.chan_ready, st_reg.chan_en,
						st_reg.mode_out, st_reg.mask,
						st_reg.busy, st_reg.ready};
					2'h2: st_next.prdata = {16'h0000, st_reg.buffer};
					default: st_next.prdata = {30'h0000_0000,
						st_reg.par_err, st_reg.overrun};
				endcase
			end
		end
		if (apb_do && hit && pwrite) begin
			case (ridx)
				2'h0: begin
					st_next.dev_addr = pwdata[`PIO_CTRL_ADDR_LSB +: AW];
					st_next.mask_bit = pwdata[`PIO_CTRL_MBIT_LSB +: 4];
				end
				2'h3: begin
					if (pwdata[`PIO_FLAG_OVR_BIT]) begin
						st_next.overrun = 1'b0;
					end
					if (pwdata[`PIO_FLAG_PAR_BIT]) begin
						st_next.par_err = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Control command decode on trailing edge
		if (p_fall[pio_pkg::PIO_P_CMD] && std_sel) begin
			case (pio_pkg::pio_cmd_type'(s_func))
				pio_pkg::PIO_CMD_WRITE: begin
					st_next.busy     = 1'b1;
					st_next.ready    = 1'b1;
					st_next.mode_out = 1'b1;
				end
				pio_pkg::PIO_CMD_READ: begin
					st_next.busy     = 1'b1;
					st_next.ready    = 1'b0;
					st_next.mode_out = 1'b0;
				end
				pio_pkg::PIO_CMD_STOP: st_next.busy = 1'b0;
				pio_pkg::PIO_CMD_CHON: begin
					st_next.chan_en    = 1'b1;
					st_next.chan_ready = 1'b1;
				end
				pio_pkg::PIO_CMD_CHOFF: st_next.chan_en = 1'b0;
				default: begin
				end
			endcase
		end

		// Output strobe loads buffer from output bus
		if (p_fall[pio_pkg::PIO_P_OTP] && sel && st_reg.mode_out) begin
			st_next.buffer = s_obus;
		end

		// Ready reset: trailing edge clears ready; buffer only on input
		if (p_fall[pio_pkg::PIO_P_RRL] && sel) begin
			st_next.ready = 1'b0;
			if (!st_reg.mode_out) begin
				st_next.buffer = `PIO_RST_WORD;
			end
		end

		// Data arrival: load word, set ready; held while pending
		if (p_fall[pio_pkg::PIO_P_ARRIVE] && st_reg.busy
			&& !st_reg.mode_out) begin
			if (st_reg.ready) begin
				st_next.overrun = 1'b1;
			end else begin
				st_next.buffer = s_pdata;
				st_next.ready  = 1'b1;
				if ((^s_pdata) != s_ppar) begin
					st_next.par_err = 1'b1;
				end
			end
		end

		// Take data: word to mechanism, ready set again
		if (p_fall[pio_pkg::PIO_P_TAKE] && st_reg.busy
			&& st_reg.mode_out) begin
			st_next.dout  = st_reg.buffer;
			st_next.ready = 1'b1;
		end

		// Mask from this device's own output bus bit
		if (p_fall[pio_pkg::PIO_P_SMK]) begin
			st_next.mask = s_obus[st_reg.mask_bit];
		end

		// End of range retires channel ready
		if (p_fall[pio_pkg::PIO_P_ERL] && s_chan) begin
			st_next.chan_ready = 1'b0;
		end

		// Normalize level overrides everything it resets
		if (p_lvl[pio_pkg::PIO_P_NORM]) begin
			st_next.busy  = 1'b0;
			st_next.ready = 1'b0;
			st_next.mask  = 1'b0;
		end

		// Skip test condition selected by function code
		if (p_lvl[pio_pkg::PIO_P_TEST] && std_sel) begin
			case (pio_pkg::pio_test_type'(s_func))
				pio_pkg::PIO_TEST_READY: test_hit = st_reg.ready;
				pio_pkg::PIO_TEST_BUSY:  test_hit = st_reg.busy;
				pio_pkg::PIO_TEST_INTR:
					test_hit = st_reg.ready & st_reg.mask;
				default: test_hit = 1'b0;
			endcase
		end
		st_next.skip = test_hit;

		// Input bus driven only while selected in input mode
		st_next.in_oe  = sel & ~st_reg.mode_out;
		st_next.in_bus = (sel & ~st_reg.mode_out) ? st_reg.buffer
			: `PIO_RST_WORD;

		// Interrupt and channel request lines
		st_next.irq  = st_reg.ready & st_reg.mask;
		st_next.csr  = st_reg.chan_en & st_reg.chan_ready
			& st_reg.ready;
		st_next.stop = st_reg.chan_en & st_reg.chan_ready
			& s_oodata;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg          <= '0;
			st_reg.dev_addr <= `PIO_RST_DEVADDR;
			st_reg.mask_bit <= `PIO_RST_MASKBIT;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign prdata                  = st_reg.prdata;
	assign pready                  = st_reg.pready;
	assign pslverr                 = st_reg.pslverr;
	assign input_bus               = st_reg.in_bus;
	assign input_bus_oe            = st_reg.in_oe;
	assign periph_word             = st_reg.dout;
	assign skip_response_line      = st_reg.skip;
	assign interrupt_request_line  = st_reg.irq;
	assign channel_service_request = st_reg.csr;
	assign block_stop_line         = st_reg.stop;
	assign parity_error_input      = st_reg.par_err;
endmodule : pio_top

// ### hw/pio_regs.svh
// Purpose: Register offsets, fields and reset values of the I/O interface
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Widths of bus fields live here too
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH
`define PIO_OFF_CTRL     12'h000
`define PIO_OFF_STATUS   12'h004
`define PIO_OFF_BUFFER   12'h008
`define PIO_OFF_FLAGS    12'h00C
`define PIO_CTRL_ADDR_LSB 0
`define PIO_CTRL_MBIT_LSB 8
`define PIO_FLAG_OVR_BIT  0
`define PIO_FLAG_PAR_BIT  1
`define PIO_RST_DEVADDR  6'h00
`define PIO_RST_MASKBIT  4'h0
`define PIO_RST_WORD     16'h0000
`define PIO_RST_DATA     32'h0000_0000
`define PIO_NORM_PULSE_MS 100
`define PIO_ADDR_W 6
`define PIO_FUNC_W 4
`define PIO_DATA_W 16
`define PIO_NPULSE 9
`define PIO_NLEVEL 45
`endif

// ### hw/pio_pkg.sv
// Purpose: Types shared by the I/O interface modules
// Assumes: pio_regs.svh gives the widths
// Notes:   Function codes ride on the function bus during pulses
`include "pio_regs.svh"
package pio_pkg;
	// Control command function codes
	typedef enum logic [3:0] {
		PIO_CMD_READ  = 4'h0,
		PIO_CMD_WRITE = 4'h1,
		PIO_CMD_STOP  = 4'h2,
		PIO_CMD_CHON  = 4'h3,
		PIO_CMD_CHOFF = 4'h4
	} pio_cmd_type;
	// Skip test condition codes
	typedef enum logic [3:0] {
		PIO_TEST_READY = 4'h1,
		PIO_TEST_BUSY  = 4'h2,
		PIO_TEST_INTR  = 4'h4
	} pio_test_type;
	// Index of each pulse in the synchronised pulse vector
	typedef enum int {
		PIO_P_CMD, PIO_P_TEST, PIO_P_OTP, PIO_P_RRL, PIO_P_SMK,
		PIO_P_ARRIVE, PIO_P_TAKE, PIO_P_ERL, PIO_P_NORM
	} pio_pidx_type;
	// Whole state of the interface controller
	typedef struct packed {
		logic                    ready;
		logic                    busy;
		logic                    mask;
		logic                    mode_out;
		logic                    chan_en;
		logic                    chan_ready;
		logic                    overrun;
		logic                    par_err;
		logic [`PIO_DATA_W-1:0]  buffer;
		logic [`PIO_DATA_W-1:0]  dout;
		logic [`PIO_DATA_W-1:0]  in_bus;
		logic                    in_oe;
		logic                    skip;
		logic                    irq;
		logic                    csr;
		logic                    stop;
		logic [`PIO_ADDR_W-1:0]  dev_addr;
		logic [3:0]              mask_bit;
		logic [31:0]             prdata;
		logic                    pready;
		logic                    pslverr;
	} pio_state_type;
endpackage : pio_pkg

// ### hw/pio_sync_if.sv
// Purpose: Carries synchronised levels and their edges between modules
// Assumes: One clock domain, pclk
// Notes:   Edges are one-cycle pulses
`timescale 1ns/10ps
interface pio_sync_if #(parameter int W = 1);
	logic [W-1:0] level;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface : pio_sync_if

// ### hw/pio_sync.sv
// Purpose: Three-stage synchroniser with agreement filter and edge detect
// Assumes: Inputs asynchronous to pclk
// Notes:   A change counts once stages two and three agree
`timescale 1ns/10ps
module pio_sync #(parameter int W = 1) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] raw,
	pio_sync_if.src           sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
		logic [W-1:0] rise;
		logic [W-1:0] fall;
	} pio_sync_type;
	pio_sync_type st_reg;
	pio_sync_type st_next;

	// Shift chain, filtered level and its edges
	always_comb begin
		st_next      = st_reg;
		st_next.s1   = raw;
		st_next.s2   = st_reg.s1;
		st_next.s3   = st_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.lvl[i] = st_reg.s3[i];
			end
		end
		st_next.rise = st_next.lvl & ~st_reg.lvl;
		st_next.fall = ~st_next.lvl & st_reg.lvl;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync.level = st_reg.lvl;
	assign sync.rise  = st_reg.rise;
	assign sync.fall  = st_reg.fall;
endmodule : pio_sync

// ### tb/pio_top_sva.sv
// Purpose: Port-level checks of the I/O device interface
// Assumes: One pclk domain, presetn low active
// Notes:   Bound into pio_top below
`timescale 1ns/10ps
`include "pio_regs.svh"
module pio_top_sva (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic [`PIO_DATA_W-1:0] input_bus,
	input wire logic                   input_bus_oe,
	input wire logic                   skip_test_cycle,
	input wire logic                   skip_response_line,
	input wire logic                   master_clear_level,
	input wire logic                   power_on_normalize_pulse,
	input wire logic                   interrupt_request_line
);
	// Answer one cycle into the access phase
	property p_apb_answer;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("late pready");
	// Answer lasts one cycle
	property p_apb_pulse;
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready;
	endproperty
	a_apb_pulse: assert property (p_apb_pulse) else $error("pready held");
	// Read data only alongside the answer
	property p_apb_idle;
		@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h0000_0000;
	endproperty
	a_apb_idle: assert property (p_apb_idle) else $error("stray prdata");
	// Error flag only with the answer, data zero
	property p_apb_err;
		@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready && prdata == 32'h0000_0000;
	endproperty
	a_apb_err: assert property (p_apb_err) else $error("bad error reply");
	// Input bus parked while not driven
	property p_bus_park;
		@(posedge pclk) disable iff (!presetn)
		!input_bus_oe |-> input_bus == 16'h0000;
	endproperty
	a_bus_park: assert property (p_bus_park) else $error("bus driven");
	// No skip answer without a test in progress
	property p_skip_idle;
		@(posedge pclk) disable iff (!presetn)
		!skip_test_cycle [*8] |-> !skip_response_line;
	endproperty
	a_skip_idle: assert property (p_skip_idle) else $error("stray skip");
	// Master clear kills request and skip answer
	property p_mclr;
		@(posedge pclk) disable iff (!presetn)
		master_clear_level [*8] |-> !interrupt_request_line && !skip_response_line;
	endproperty
	a_mclr: assert property (p_mclr) else $error("clear ignored");
	// Power-on normalize kills the request too
	property p_pon;
		@(posedge pclk) disable iff (!presetn)
		power_on_normalize_pulse [*8] |-> !interrupt_request_line;
	endproperty
	a_pon: assert property (p_pon) else $error("normalize ignored");
endmodule : pio_top_sva

bind pio_top pio_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.input_bus(input_bus), .input_bus_oe(input_bus_oe),
	.skip_test_cycle(skip_test_cycle), .skip_response_line(skip_response_line),
	.master_clear_level(master_clear_level),
	.power_on_normalize_pulse(power_on_normalize_pulse),
	.interrupt_request_line(interrupt_request_line));

// ### tb/pio_host.sv
// Purpose: Host bus model issuing commands, tests and word transfers
// Assumes: Pulses active high, driven just after pclk edges
// Notes:   strobes: 0 command 1 test 2 output 3 ready reset 4 mask 5 range
`timescale 1ns/10ps
module pio_host (
	input  wire logic        pclk,
	input  wire logic [15:0] input_bus,
	input  wire logic        skip_response_line,
	output logic      [5:0]  address_bus,
	output logic      [3:0]  function_bus,
	output logic      [15:0] output_bus,
	output logic      [5:0]  strobes,
	output logic             channel_address_line,
	output logic      [7:0]  interrupt_acknowledge_lines
);
	// Quiet bus at start
	initial begin
		{channel_address_line, address_bus} = 7'h00;
		function_bus = 4'h0;
		output_bus = 16'h0000;
		strobes = 6'h00;
		interrupt_acknowledge_lines = 8'h00;
	end
	// Acknowledge of the serviced level, held about 2.0 us
	task automatic ack(input int k);
		interrupt_acknowledge_lines[k] <= 1'b1;
		repeat (200) @(posedge pclk);
		interrupt_acknowledge_lines <= 8'h00;
		@(posedge pclk);
	endtask : ack
	// One pulse framed by steady address and data; skip taken while held
	task automatic pulse(input int k, input logic [6:0] a, input logic [3:0] f,
		input logic [15:0] d, output logic s);
		{channel_address_line, address_bus} <= a;
		function_bus <= f;
		output_bus <= d;
		repeat (2) @(posedge pclk);
		strobes[k] <= 1'b1;
		repeat (7) @(posedge pclk);
		s = skip_response_line;
		strobes[k] <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask : pulse
	// Input word: bus read only after a positive ready test
	task automatic in_word(input logic [5:0] a, output logic ok,
		output logic [15:0] w);
		logic s;
		pulse(1, {1'b0, a}, 4'h1, 16'h0000, ok);
		w = ok ? input_bus : 16'h0000;
		if (ok) begin
			pulse(3, {1'b0, a}, 4'h0, 16'h0000, s);
		end
	endtask : in_word
endmodule : pio_host

// ### tb/tb_pio_top.sv
// Purpose: Self-checking bench for the I/O device interface
// Assumes: pio_host plays the host, bench plays peripheral and APB
// Notes:   Read results are matched against a queue of notes
`timescale 1ns/10ps
module tb_pio_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] ob, ib, pw, pd, w, d, got;
	logic [5:0]  ab, st, a;
	logic [3:0]  fb, m;
	logic [7:0]  ack_l;
	logic [1:0]  pp, ln;
	logic        cal, par, ood, oe, skp, irq, csr, bstop, perr, ok, s;
	logic [32:0] q_exp[$], q_msk[$];
	int          num_errors, n_compared, cyc;
	pio_host h (.pclk(pclk), .input_bus(ib), .skip_response_line(skp),
		.address_bus(ab), .function_bus(fb), .output_bus(ob), .strobes(st),
		.channel_address_line(cal), .interrupt_acknowledge_lines(ack_l));
	pio_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.address_bus(ab), .function_bus(fb), .output_bus(ob),
		.control_command(st[0]), .skip_test_cycle(st[1]),
		.output_strobe(st[2]), .ready_reset_pulse(st[3]),
		.mask_set_pulse(st[4]), .channel_address_line(cal),
		.end_of_range_pulse(st[5]), .master_clear_level(ln[0]),
		.power_on_normalize_pulse(ln[1]), .data_arrival_pulse(pp[0]),
		.take_data_pulse(pp[1]), .periph_data(pd), .periph_parity(par),
		.periph_out_of_data(ood), .input_bus(ib), .input_bus_oe(oe),
		.periph_word(pw), .skip_response_line(skp),
		.interrupt_request_line(irq), .channel_service_request(csr),
		.block_stop_line(bstop), .parity_error_input(perr));
	// Clock
	always #5 pclk = ~pclk;
	// Compare one result
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	// Verdict and end of run
	task automatic close_out;
		if (num_errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out
	// APB transfer held until pready
	task automatic apb(input logic wr, input logic [11:0] ad,
		input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Note the expected read reply, then read
	task automatic rd(input logic [11:0] ad, input logic [32:0] e,
		input logic [32:0] k);
		q_exp.push_back(e);
		q_msk.push_back(k);
		apb(1'b0, ad, 32'h0000_0000);
	endtask : rd
	// Peripheral pulse: 0 data arrival, 1 take data
	task automatic per(input int k, input logic [15:0] v, input logic p);
		pd <= v;
		par <= p;
		repeat (2) @(posedge pclk);
		pp[k] <= 1'b1;
		repeat (4) @(posedge pclk);
		pp <= 2'b00;
		repeat (8) @(posedge pclk);
	endtask : per
	// Hold one normalize source: 0 master clear, 1 power-on
	task automatic norm(input int k);
		ln[k] <= 1'b1;
		repeat (12) @(posedge pclk);
		ln <= 2'b00;
		repeat (8) @(posedge pclk);
	endtask : norm
	// Read reply watcher
	always @(posedge pclk) begin
		if (pready === 1'b1 && pwrite === 1'b0) begin
			chk({pslverr, prdata} & q_msk[0], q_exp[0]);
			void'(q_exp.pop_front());
			void'(q_msk.pop_front());
		end
	end
	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			close_out();
		end
	end
	// Main sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite, par, ood} = 7'h00;
		{paddr, pwdata, pd, pp, ln} = 64'h0000_0000_0000_0000;
		{num_errors, n_compared, cyc} = 96'h0;
		void'($urandom(32'h86e9_6582));
		a = 6'($urandom_range(63, 1));
		m = 4'($urandom);
		w = 16'($urandom);
		d = 16'($urandom);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h004, 33'h0, '1);
		rd(12'h000, 33'h0, '1);
		apb(1'b1, 12'h000, {20'h0_0000, m, 2'b00, a});
		rd(12'h000, {21'h0, m, 2'b00, a}, '1);
		apb(1'b1, 12'h004, 32'h0000_00FF);
		rd(12'h004, 33'h0, '1);
		rd(12'h010, 33'h1_0000_0000, '1);
		h.pulse(0, {1'b0, a}, 4'h0, 16'h0000, s);
		rd(12'h004, 33'h2, 33'hF);
		h.pulse(1, {1'b0, a}, 4'h1, 16'h0000, s);
		chk(s, 0);
		h.pulse(1, {1'b0, a}, 4'h2, 16'h0000, s);
		chk(s, 1);
		per(0, w, ^w);
		rd(12'h004, 33'h3, 33'hF);
		h.pulse(4, 7'h00, 4'h0, 16'h0001 << m, s);
		chk(irq, 1);
		h.pulse(1, {1'b0, a ^ 6'h01}, 4'h4, 16'h0000, s);
		chk(s, 0);
		chk(oe, 0);
		h.pulse(1, {1'b0, a}, 4'h4, 16'h0000, s);
		chk(s, 1);
		h.ack(0);
		chk(irq, 1);
		rd(12'h008, {17'h0, w}, '1);
		h.in_word(a, ok, got);
		chk({ok, got}, {1'b1, w});
		chk(oe, 1);
		rd(12'h008, 33'h0, '1);
		rd(12'h004, 33'h6, 33'hF);
		chk(irq, 0);
		h.in_word(a, ok, got);
		chk(ok, 0);
		h.pulse(0, {1'b0, a}, 4'h1, 16'h0000, s);
		rd(12'h004, 33'hF, 33'hF);
		chk(irq, 1);
		h.pulse(2, {1'b0, a}, 4'h0, d, s);
		h.pulse(3, {1'b0, a}, 4'h0, 16'h0000, s);
		rd(12'h004, 33'hE, 33'hF);
		rd(12'h008, {17'h0, d}, '1);
		chk(oe, 0);
		chk(irq, 0);
		per(1, 16'h0000, 1'b0);
		chk({irq, pw}, {1'b1, d});
		h.pulse(4, 7'h00, 4'h0, ~(16'h0001 << m), s);
		chk(irq, 0);
		h.pulse(0, {1'b0, a}, 4'h3, 16'h0000, s);
		chk(csr, 1);
		ood <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(bstop, 1);
		h.pulse(5, {1'b1, a}, 4'h0, 16'h0000, s);
		chk(csr, 0);
		ood <= 1'b0;
		h.pulse(2, {1'b1, a ^ 6'h01}, 4'h0, w, s);
		rd(12'h008, {17'h0, w}, '1);
		h.pulse(0, {1'b0, a}, 4'h4, 16'h0000, s);
		h.pulse(0, {1'b0, a}, 4'h0, 16'h0000, s);
		per(0, d, ~^d);
		chk(perr, 1);
		per(0, w, ^w);
		rd(12'h008, {17'h0, d}, '1);
		rd(12'h00C, 33'h3, 33'h3);
		apb(1'b1, 12'h00C, 32'h0000_0002);
		repeat (3) @(posedge pclk);
		chk(perr, 0);
		h.pulse(4, 7'h00, 4'h0, 16'h0001 << m, s);
		chk(irq, 1);
		norm(0);
		rd(12'h004, 33'h0, 33'h7);
		h.pulse(0, {1'b0, a}, 4'h1, 16'h0000, s);
		h.pulse(0, {1'b0, a}, 4'h2, 16'h0000, s);
		rd(12'h004, 33'h9, 33'hF);
		h.pulse(4, 7'h00, 4'h0, 16'h0001 << m, s);
		chk(irq, 1);
		norm(1);
		rd(12'h004, 33'h0, 33'h7);
		close_out();
	end
endmodule : tb_pio_top
